/* include/rate_divider_defs.svh */
// Behaviour
// [RULE1] Divider counts the current system clock only.
// [RULE2] Receive line sampled thrice, majority decides.
// [RULE3] Async 8-bit low speed: clock/(64(n+1)).
// [RULE4] Async 16-bit low speed: clock/(16(n+1)).
// [RULE5] Sync 8-bit: clock/(4(n+1)), speed ignored.
// [RULE6] Divisor is high byte above low byte.
// [RULE7] Other modes: prescale 16 or 4.
// [RULE8] Divisor byte write restarts divider timer.
// [RULE9] 8-bit after reset; high byte then ignored.
// [RULE10] Sync mode ignores high-speed selection.
`ifndef RATE_DIVIDER_DEFS_SVH
`define RATE_DIVIDER_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_TX_CONTROL_STATUS 3'h0
`define OFS_RX_CONTROL_STATUS 3'h1
`define OFS_RATE_CONTROL 3'h2
`define OFS_DIVISOR_HIGH 3'h3
`define OFS_DIVISOR_LOW 3'h4
`define OFS_RATE_STATUS 3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_SYNC_MODE 4
`define BIT_HIGH_SPEED 2
`define BIT_WIDE_DIVIDER 3
`define BIT_PORT_ENABLE 7

// ----------------------------------------
// Reset values and prescale counts
// ----------------------------------------
`define RST_BYTE 8'h00
`define PRESCALE_64 7'h40
`define PRESCALE_16 7'h10
`define PRESCALE_4 7'h04
`define SAMPLE_COUNT 2'h3

`endif

/* include/rate_divider_pkg.sv */
`default_nettype none
package rate_divider_pkg;

  // One register-port request.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Mode decoded from the control bits.
  typedef enum logic [1:0] {
    MODE_ASYNC_LOW,
    MODE_ASYNC_HIGH,
    MODE_SYNC
  } rate_mode_t;

endpackage : rate_divider_pkg
`default_nettype wire

/* logic/rate_divider.sv */
// The plain strobed port and the register addresses are this design's own decisions.
`include "rate_divider_defs.svh"
`default_nettype none
module rate_divider
  import rate_divider_pkg::*;
#(
  parameter int DIV_WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire reg_req_t req,
  output logic [7:0] rdata,
  input wire logic rx_line,
  output logic bit_tick,
  output logic sample_tick,
  output logic rx_level
);

  // The divisor pair is exactly two bytes wide, so no other width can be served.
  if (DIV_WIDTH != 16) begin : g_bad_width
    $error("DIV_WIDTH must be 16");
  end

  logic [7:0] tx_control_status_reg;
  logic [7:0] rx_control_status_reg;
  logic [7:0] rate_control_reg;
  logic [7:0] divisor_high_byte_reg;
  logic [7:0] divisor_low_byte_reg;
  logic [DIV_WIDTH-1:0] timer_reg;
  logic [6:0] pre_reg;
  logic [1:0] samp_reg;
  logic [1:0] votes_reg;
  logic div_write;
  logic wr_tx;
  logic wr_rx;
  logic wr_rate;
  logic wr_hi;
  logic wr_lo;
  logic port_enable;
  logic restart;
  logic pre_wrap;
  logic timer_wrap;
  logic sample_hit;
  logic wide;
  logic [DIV_WIDTH-1:0] divisor;
  logic [6:0] prescale;
  rate_mode_t mode;

  // ----------------------------------------
  // Mode and divisor decode
  // ----------------------------------------
  assign wide = rate_control_reg[`BIT_WIDE_DIVIDER];
  // High byte only counts when the wide divider is selected.
  assign divisor = wide ? {divisor_high_byte_reg, divisor_low_byte_reg} // [RULE6]
                        : {8'h00, divisor_low_byte_reg}; // [RULE9]
  assign div_write = wr_hi || wr_lo;

  // Sync mode wins over the speed bit, which it never looks at.
  always_comb begin
    if (tx_control_status_reg[`BIT_SYNC_MODE]) begin
      mode = MODE_SYNC; // [RULE10]
    end else if (tx_control_status_reg[`BIT_HIGH_SPEED]) begin
      mode = MODE_ASYNC_HIGH;
    end else begin
      mode = MODE_ASYNC_LOW;
    end
  end

  // Prescale per mode; the whole rate is prescale times divisor plus one.
  always_comb begin
    unique case (mode)
      MODE_ASYNC_LOW: prescale = wide ? `PRESCALE_16 : `PRESCALE_64; // [RULE3] [RULE4]
      MODE_ASYNC_HIGH: prescale = wide ? `PRESCALE_4 : `PRESCALE_16; // [RULE7]
      MODE_SYNC: prescale = `PRESCALE_4; // [RULE5] [RULE7]
    endcase
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // One strobe per register keeps each store in its own small process.
  // Writes to unmapped offsets match no strobe and are dropped.
  assign wr_tx = req.wr && (req.addr == `OFS_TX_CONTROL_STATUS);
  assign wr_rx = req.wr && (req.addr == `OFS_RX_CONTROL_STATUS);
  assign wr_rate = req.wr && (req.addr == `OFS_RATE_CONTROL);
  assign wr_hi = req.wr && (req.addr == `OFS_DIVISOR_HIGH);
  assign wr_lo = req.wr && (req.addr == `OFS_DIVISOR_LOW);

  // Transmit control: holds the sync mode and speed selection bits.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_control_status_reg <= `RST_BYTE;
    end else if (wr_tx) begin
      tx_control_status_reg <= req.wdata;
    end
  end

  // Receive control: its top bit gates the whole divider.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_control_status_reg <= `RST_BYTE;
    end else if (wr_rx) begin
      rx_control_status_reg <= req.wdata;
    end
  end

  // Rate control keeps only its writable bits, so reserved bits read zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_control_reg <= `RST_BYTE; // [RULE9]
    end else if (wr_rate) begin
      rate_control_reg <= req.wdata & 8'h1b;
    end
  end

  // High divisor byte; stored even while the narrow divider ignores it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divisor_high_byte_reg <= `RST_BYTE;
    end else if (wr_hi) begin
      divisor_high_byte_reg <= req.wdata;
    end
  end

  // Low divisor byte.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divisor_low_byte_reg <= `RST_BYTE;
    end else if (wr_lo) begin
      divisor_low_byte_reg <= req.wdata;
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        `OFS_TX_CONTROL_STATUS: rdata <= tx_control_status_reg;
        `OFS_RX_CONTROL_STATUS: rdata <= rx_control_status_reg;
        `OFS_RATE_CONTROL: rdata <= rate_control_reg;
        `OFS_DIVISOR_HIGH: rdata <= divisor_high_byte_reg;
        `OFS_DIVISOR_LOW: rdata <= divisor_low_byte_reg;
        `OFS_RATE_STATUS: rdata <= {5'h00, rx_level, mode};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Divider timer
  // ----------------------------------------
  // Counts system clock edges only, so a clock change needs a new divisor.
  assign port_enable = rx_control_status_reg[`BIT_PORT_ENABLE];
  // A divisor write restarts the count, so a new rate never waits out an old one.
  assign restart = div_write || !port_enable; // [RULE8]
  assign pre_wrap = pre_reg >= prescale - 7'h01; // [RULE1]
  assign timer_wrap = timer_reg >= divisor;
  // Three samples land in the middle of the bit period.
  assign sample_hit = (timer_reg == (divisor >> 1)) && (pre_reg >= (prescale >> 1) - 7'h02)
                      && (pre_reg < (prescale >> 1) + 7'h01);

  // Prescale counter, one step per system clock.
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      pre_reg <= 7'h00; // [RULE8]
    end else if (pre_wrap) begin
      pre_reg <= 7'h00;
    end else begin
      pre_reg <= pre_reg + 7'h01;
    end
  end

  // Divisor timer, one step per prescale wrap.
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      timer_reg <= '0; // [RULE8]
    end else if (pre_wrap) begin
      if (timer_wrap) begin
        timer_reg <= '0;
      end else begin
        timer_reg <= timer_reg + {{(DIV_WIDTH - 1){1'b0}}, 1'b1};
      end
    end
  end

  // Bit pulse at the end of each full period.
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= pre_wrap && timer_wrap;
    end
  end

  // Sample pulses never fall on a wrap step, so a burst stays inside one bit.
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= !pre_wrap && sample_hit;
    end
  end

  // ----------------------------------------
  // Majority detect
  // ----------------------------------------
  // The two earlier samples of a burst; the third is the line itself.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      votes_reg <= 2'h3;
    end else if (sample_tick) begin
      votes_reg <= {votes_reg[0], rx_line};
    end
  end

  // Sample counter; a bit boundary realigns it so a cut burst cannot skew any vote after that boundary.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      samp_reg <= 2'h0;
    end else if (sample_tick) begin
      if (samp_reg == `SAMPLE_COUNT - 2'h1) begin
        samp_reg <= 2'h0;
      end else begin
        samp_reg <= samp_reg + 2'h1;
      end
    end else if (bit_tick) begin
      samp_reg <= 2'h0;
    end
  end

  // Two of three samples decide, so a single glitch cannot flip the level.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_level <= 1'b1;
    end else if (sample_tick && samp_reg == `SAMPLE_COUNT - 2'h1) begin
      rx_level <= (votes_reg[1] & votes_reg[0]) | (votes_reg[1] & rx_line) | (votes_reg[0] & rx_line); // [RULE2]
    end
  end

endmodule : rate_divider
`default_nettype wire

/* tb/rate_divider_props.sv */
`default_nettype none
module rate_divider_props
  import rate_divider_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rx_line,
  input wire logic bit_tick,
  input wire logic sample_tick,
  input wire logic rx_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // The shortest period is 4 clocks, so three quiet cycles must follow.
  sequence s_quiet;
    !bit_tick [*3];
  endsequence
  property p_restart;
    req.wr && (req.addr inside {3'h3, 3'h4}) |=> s_quiet;
  endproperty
  a_restart: assert property (p_restart) else $error("tick soon after divisor write");
  property p_gap;
    bit_tick |=> s_quiet;
  endproperty
  a_gap: assert property (p_gap) else $error("ticks too close");
  property p_idle;
    !req.rd |=> rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside read");
  // Samples come in bursts of three at most, one burst per vote.
  sequence s_burst;
    sample_tick [*3];
  endsequence
  property p_burst;
    s_burst |=> !sample_tick;
  endproperty
  a_burst: assert property (p_burst) else $error("sample burst too long");
  property p_level_hold;
    !sample_tick |=> $stable(rx_level);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level moved without a sample");
  property p_apart;
    bit_tick |-> !sample_tick;
  endproperty
  a_apart: assert property (p_apart) else $error("sample on a bit boundary");
endmodule : rate_divider_props
bind rate_divider rate_divider_props rate_divider_props_inst (.clk(clk), .rst_n(rst_n), .req(req),
  .rdata(rdata), .rx_line(rx_line), .bit_tick(bit_tick), .sample_tick(sample_tick), .rx_level(rx_level));
`default_nettype wire

/* tb/serial_node.sv */
`default_nettype none
module serial_node (
  input wire logic clk,
  input wire logic bit_tick,
  input wire logic send_bit,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // The remote sender moves its line once per bit, idle high.
  initial rx_line = 1'b1;
  always @(posedge clk) begin
    if (bit_tick) begin
      rx_line <= send_bit;
    end
  end
endmodule : serial_node
`default_nettype wire

/* tb/rate_divider_tb.sv */
`default_nettype none
module rate_divider_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rate_divider_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic send_bit = 1'b1;
  reg_req_t req = '0;
  logic [7:0] rdata, d;
  logic [15:0] n;
  logic rx_line, bit_tick, sample_tick, rx_level;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  // Columns: tx control, rate control, high, low, period, mode.
  logic [15:0] cfg [6][6] = '{'{0, 0, 1, 2, 192, 0}, '{4, 0, 0, 2, 48, 1}, '{0, 8, 1, 0, 4112, 0},
    '{4, 8, 0, 3, 16, 1}, '{20, 0, 0, 3, 16, 2}, '{16, 8, 0, 5, 24, 2}};
  always #4 clk = ~clk;
  rate_divider rate_divider_inst (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rx_line(rx_line),
    .bit_tick(bit_tick), .sample_tick(sample_tick), .rx_level(rx_level));
  serial_node serial_node_inst (.clk(clk), .bit_tick(bit_tick), .send_bit(send_bit), .rx_line(rx_line));
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  // A hung wait ends the run here, counted as a mismatch.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [2:0] a, logic [7:0] v);
    @(posedge clk) req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk) req <= '0;
  endtask : wr
  task automatic rd(logic [2:0] a, output logic [7:0] v);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req <= '0;
    #1 v = rdata;
  endtask : rd
  // Counts clocks between two ticks, so restart latency cannot skew it.
  task automatic period(output logic [15:0] c);
    @(posedge clk iff bit_tick);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (bit_tick !== 1'b1);
  endtask : period
  // Every mode in turn, then line voting and read-back.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr(3'h1, 8'h80);
    for (int i = 0; i < 6; i++) begin
      wr(3'h0, cfg[i][0][7:0]);
      wr(3'h2, cfg[i][1][7:0]);
      wr(3'h3, cfg[i][2][7:0]);
      wr(3'h4, cfg[i][3][7:0]);
      period(n);
      chk("bit period", n, cfg[i][4]);
      rd(3'h5, d);
      chk("status", 16'(d), 16'h0004 | cfg[i][5]);
    end
    send_bit <= 1'b0;
    period(n);
    period(n);
    chk("rx level", 16'(rx_level), 16'h0000);
    rd(3'h4, d);
    chk("divisor low", 16'(d), 16'h0005);
    rd(3'h7, d);
    chk("unmapped", 16'(d), 16'h0000);
    wr(3'h2, 8'hff);
    rd(3'h2, d);
    chk("rate control mask", 16'(d), 16'h001b);
    summarize();
  end
endmodule : rate_divider_tb
`default_nettype wire
